// >>> design/isr_pkg.sv
// Shared constants and types for the serial register port and its bus master
package isr_pkg;

	// ==========================================================
	// Addressing
	localparam logic [4:0] ISR_ADDR_HI   = 5'h16;
	localparam logic [7:0] ISR_GC_ADDR   = 8'h00;
	localparam logic [7:0] ISR_GC_RST    = 8'h06;
	localparam logic [7:0] ISR_GC_LATCH  = 8'h04;
	localparam logic [7:0] ISR_ADDR_RST  = 8'h00;
	localparam logic [3:0] ISR_BYTE_BITS = 4'h8;

	// ==========================================================
	// Timing
	localparam int ISR_CLK_MHZ      = 100;
	localparam int ISR_SCL_KHZ      = 250;
	localparam int ISR_QTR_CYC      = (ISR_CLK_MHZ * 1000) / (ISR_SCL_KHZ * 4);
	localparam int ISR_GAP_NS       = 2000;
	localparam int ISR_GAP_CYC      = (ISR_GAP_NS * ISR_CLK_MHZ + 999) / 1000;
	localparam int ISR_CNT_W        = 9;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		DS_IDLE, DS_RX, DS_ACK, DS_TX, DS_TXACK
	} isr_dev_st_t;

	typedef enum logic [2:0] {
		RL_HDR, RL_REG, RL_DATA, RL_GCCMD, RL_GCEND, RL_RD
	} isr_role_t;

	typedef enum logic [2:0] {
		MS_IDLE, MS_START, MS_BIT, MS_STOP, MS_GAP
	} isr_host_st_t;

	typedef enum logic [1:0] {
		CMD_START, CMD_WRITE, CMD_READ, CMD_STOP
	} isr_cmd_t;

endpackage : isr_pkg

// >>> design/isr_if.sv
// Two-wire bus between the host end and the register port end
`timescale 1ns/1ps
interface isr_if;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic s_sda_o;
	logic s_sda_oe;
	logic scl;
	logic sda;

	// Open-drain wired AND with pull-ups
	assign scl = m_scl_oe ? m_scl_o : 1'b1;
	assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);

	modport host (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe, input scl, input sda);
	modport dev  (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface : isr_if

// >>> design/isr_dev_end.sv
// Register port end: serial slave with address counter and general call
`timescale 1ns/1ps
module isr_dev_end (
	isr_if.dev         bus,
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic [1:0] adr_sel_i,
	input  wire logic [7:0] reg_rdata_i,
	output logic [7:0]      reg_addr_o,
	output logic            reg_wr_o,
	output logic [7:0]      reg_wdata_o,
	output logic            reg_rd_o,
	output logic            soft_rst_o
);

	// ==========================================================
	// Synchronisers and edge detection
	logic [1:0] scl_sync_q;
	logic [1:0] sda_sync_q;
	logic [1:0] sel_sync0_q;
	logic [1:0] sel_sync1_q;
	logic       scl_p_q;
	logic       sda_p_q;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			scl_sync_q  <= 2'h3;
			sda_sync_q  <= 2'h3;
			scl_p_q     <= 1'b1;
			sda_p_q     <= 1'b1;
			sel_sync0_q <= 2'h0;
			sel_sync1_q <= 2'h0;
		end else begin
			scl_sync_q  <= {scl_sync_q[0], bus.scl};
			sda_sync_q  <= {sda_sync_q[0], bus.sda};
			scl_p_q     <= scl_sync_q[1];
			sda_p_q     <= sda_sync_q[1];
			sel_sync0_q <= adr_sel_i;
			sel_sync1_q <= sel_sync0_q;
		end
	end

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	assign scl_s     = scl_sync_q[1];
	assign sda_s     = sda_sync_q[1];
	assign scl_rise  = scl_s & ~scl_p_q;
	assign scl_fall  = ~scl_s & scl_p_q;
	assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;

	// ==========================================================
	// Slave address with relatched strap bits
	logic [1:0] prog_q;
	logic [1:0] lat_q;
	logic       relatch;
	logic       soft_rst_q;

	// Straps taken only once the synchroniser holds pin values, never its reset fill
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prog_q <= 2'h0;
			lat_q  <= 2'h0;
		end else if (relatch) begin
			lat_q <= 2'h0;
		end else if (lat_q != 2'h3) begin
			lat_q <= lat_q + 2'h1;
			if (lat_q == 2'h2)
				prog_q <= sel_sync1_q;
		end
	end

	// ==========================================================
	// Byte receive decode
	isr_pkg::isr_dev_st_t st_q;
	isr_pkg::isr_role_t   role_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic [7:0] rx_byte;
	logic       byte_done;
	logic       hdr_hit;
	logic       gc_hit;
	logic       rd_acked;

	assign rx_byte   = {sh_q[6:0], sda_s};
	assign byte_done = (st_q == isr_pkg::DS_RX) && scl_rise && (cnt_q == isr_pkg::ISR_BYTE_BITS - 4'h1);
	assign hdr_hit   = rx_byte[7:1] == {isr_pkg::ISR_ADDR_HI, prog_q};
	assign gc_hit    = rx_byte == isr_pkg::ISR_GC_ADDR;
	assign rd_acked  = (st_q == isr_pkg::DS_TXACK) && scl_rise && !sda_s;
	assign relatch   = byte_done && (role_q == isr_pkg::RL_GCCMD)
		&& (rx_byte == isr_pkg::ISR_GC_RST || rx_byte == isr_pkg::ISR_GC_LATCH);

	// ==========================================================
	// Bus state machine
	logic oe_q;
	logic rd_q;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_q   <= isr_pkg::DS_IDLE;
			role_q <= isr_pkg::RL_HDR;
			cnt_q  <= 4'h0;
			sh_q   <= 8'h00;
			oe_q   <= 1'b0;
			rd_q   <= 1'b0;
		end else if (start_det) begin
			st_q   <= isr_pkg::DS_RX;
			role_q <= isr_pkg::RL_HDR;
			cnt_q  <= 4'h0;
			oe_q   <= 1'b0;
		end else if (stop_det) begin
			st_q <= isr_pkg::DS_IDLE;
			oe_q <= 1'b0;
		end else begin
			rd_q <= 1'b0;
			case (st_q)
				isr_pkg::DS_RX: begin
					if (scl_rise && cnt_q < isr_pkg::ISR_BYTE_BITS) begin
						sh_q  <= rx_byte;
						cnt_q <= cnt_q + 4'h1;
						if (byte_done) begin
							case (role_q)
								isr_pkg::RL_HDR: begin
									if (hdr_hit)
										role_q <= rx_byte[0] ? isr_pkg::RL_RD : isr_pkg::RL_REG;
									else if (gc_hit)
										role_q <= isr_pkg::RL_GCCMD;
									else
										st_q <= isr_pkg::DS_IDLE;
								end
								isr_pkg::RL_REG:   role_q <= isr_pkg::RL_DATA;
								isr_pkg::RL_GCCMD: role_q <= isr_pkg::RL_GCEND;
								default:           role_q <= role_q;
							endcase
						end
					end else if (scl_fall && cnt_q == isr_pkg::ISR_BYTE_BITS) begin
						oe_q  <= 1'b1;
						cnt_q <= 4'h0;
						st_q  <= isr_pkg::DS_ACK;
					end
				end
				isr_pkg::DS_ACK: begin
					if (scl_fall) begin
						if (role_q == isr_pkg::RL_RD) begin
							oe_q  <= ~reg_rdata_i[7];
							sh_q  <= {reg_rdata_i[6:0], 1'b0};
							cnt_q <= 4'h1;
							rd_q  <= 1'b1;
							st_q  <= isr_pkg::DS_TX;
						end else begin
							oe_q <= 1'b0;
							st_q <= (role_q == isr_pkg::RL_GCEND) ? isr_pkg::DS_IDLE : isr_pkg::DS_RX;
						end
					end
				end
				isr_pkg::DS_TX: begin
					if (scl_fall) begin
						if (cnt_q == isr_pkg::ISR_BYTE_BITS) begin
							oe_q <= 1'b0;
							st_q <= isr_pkg::DS_TXACK;
						end else begin
							oe_q  <= ~sh_q[7];
							sh_q  <= {sh_q[6:0], 1'b0};
							cnt_q <= cnt_q + 4'h1;
						end
					end
				end
				isr_pkg::DS_TXACK: begin
					if (scl_rise)
						st_q <= sda_s ? isr_pkg::DS_IDLE : isr_pkg::DS_ACK;
				end
				default: begin
					oe_q <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// Address counter and register strobes
	logic [7:0] addr_q;
	logic       wr_q;
	logic [7:0] wdata_q;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_q    <= 1'b0;
			wdata_q <= 8'h00;
		end else begin
			wr_q <= byte_done && (role_q == isr_pkg::RL_DATA);
			if (byte_done)
				wdata_q <= rx_byte;
		end
	end

	// Natural 8-bit overflow gives the wrap to location zero
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			addr_q <= isr_pkg::ISR_ADDR_RST;
		else if (soft_rst_q)
			addr_q <= isr_pkg::ISR_ADDR_RST;
		else if (byte_done && role_q == isr_pkg::RL_REG)
			addr_q <= rx_byte;
		else if (wr_q || rd_acked)
			addr_q <= addr_q + 8'h01;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			soft_rst_q <= 1'b0;
		else
			soft_rst_q <= relatch && (rx_byte == isr_pkg::ISR_GC_RST);
	end

	assign reg_addr_o  = addr_q;
	assign reg_wr_o    = wr_q;
	assign reg_wdata_o = wdata_q;
	assign reg_rd_o    = rd_q;
	assign soft_rst_o  = soft_rst_q;
	assign bus.s_sda_o  = 1'b0;
	assign bus.s_sda_oe = oe_q;

endmodule : isr_dev_end

// >>> design/isr_host_end.sv
// Host end: byte-level two-wire bus master
`timescale 1ns/1ps
module isr_host_end (
	isr_if.host        bus,
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             cmd_valid_i,
	input  wire isr_pkg::isr_cmd_t cmd_i,
	input  wire logic [7:0]       cmd_data_i,
	input  wire logic             cmd_last_i,
	output logic                  cmd_ready_o,
	output logic                  rsp_valid_o,
	output logic [7:0]            rsp_data_o,
	output logic                  rsp_ack_o
);

	localparam int ISR_W = isr_pkg::ISR_CNT_W;
	localparam logic [ISR_W-1:0] QTR_LAST = ISR_W'(isr_pkg::ISR_QTR_CYC - 1);
	localparam logic [ISR_W-1:0] GAP_LAST = ISR_W'(isr_pkg::ISR_GAP_CYC - 1);

	// ==========================================================
	// Bus input synchroniser
	logic [1:0] sda_sync_q;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			sda_sync_q <= 2'h3;
		else
			sda_sync_q <= {sda_sync_q[0], bus.sda};
	end

	// ==========================================================
	// Sequencer: four quarter phases per SCL bit
	isr_pkg::isr_host_st_t st_q;
	logic [ISR_W-1:0] tmr_q;
	logic [1:0] ph_q;
	logic [3:0] bit_q;
	logic [8:0] sh_q;
	logic       rd_q;
	logic       scl_oe_q;
	logic       sda_oe_q;
	logic       rdy_q;
	logic       rv_q;
	logic [7:0] rdat_q;
	logic       rack_q;
	logic       tick;

	assign tick = (tmr_q == QTR_LAST);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_q     <= isr_pkg::MS_IDLE;
			tmr_q    <= '0;
			ph_q     <= 2'h0;
			bit_q    <= 4'h0;
			sh_q     <= 9'h000;
			rd_q     <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			rdy_q    <= 1'b0;
			rv_q     <= 1'b0;
			rdat_q   <= 8'h00;
			rack_q   <= 1'b0;
		end else begin
			rv_q <= 1'b0;
			// Gap runs on one unbroken count, so it may exceed a quarter period
			tmr_q <= (st_q == isr_pkg::MS_IDLE || (tick && st_q != isr_pkg::MS_GAP)) ? '0 : tmr_q + 1'b1;
			case (st_q)
				isr_pkg::MS_IDLE: begin
					rdy_q <= 1'b1;
					if (cmd_valid_i && rdy_q) begin
						rdy_q <= 1'b0;
						ph_q  <= 2'h0;
						bit_q <= 4'h0;
						rd_q  <= (cmd_i == isr_pkg::CMD_READ);
						// Read bytes carry the master ack in the ninth slot
						sh_q  <= (cmd_i == isr_pkg::CMD_READ) ? {8'hFF, cmd_last_i} : {cmd_data_i, 1'b1};
						case (cmd_i)
							isr_pkg::CMD_START: st_q <= isr_pkg::MS_START;
							isr_pkg::CMD_STOP:  st_q <= isr_pkg::MS_STOP;
							default:            st_q <= isr_pkg::MS_BIT;
						endcase
					end
				end
				isr_pkg::MS_START: begin
					if (tick) begin
						ph_q <= ph_q + 2'h1;
						case (ph_q)
							2'h0: begin scl_oe_q <= 1'b1; sda_oe_q <= 1'b0; end
							2'h1: scl_oe_q <= 1'b0;
							2'h2: sda_oe_q <= 1'b1;
							default: begin
								scl_oe_q <= 1'b1;
								st_q     <= isr_pkg::MS_IDLE;
							end
						endcase
					end
				end
				isr_pkg::MS_BIT: begin
					if (tick) begin
						ph_q <= ph_q + 2'h1;
						case (ph_q)
							2'h0: begin
								scl_oe_q <= 1'b1;
								sda_oe_q <= ~sh_q[8];
							end
							2'h1: scl_oe_q <= 1'b0;
							2'h2: sh_q <= {sh_q[7:0], sda_sync_q[1]};
							default: begin
								scl_oe_q <= 1'b1;
								bit_q    <= bit_q + 4'h1;
								if (bit_q == isr_pkg::ISR_BYTE_BITS) begin
									sda_oe_q <= 1'b0;
									rv_q     <= 1'b1;
									// Read data sat in the top eight samples
									rdat_q   <= rd_q ? sh_q[8:1] : 8'h00;
									rack_q   <= ~sh_q[0];
									st_q     <= isr_pkg::MS_IDLE;
								end
							end
						endcase
					end
				end
				isr_pkg::MS_STOP: begin
					if (tick) begin
						ph_q <= ph_q + 2'h1;
						case (ph_q)
							2'h0: begin scl_oe_q <= 1'b1; sda_oe_q <= 1'b1; end
							2'h1: scl_oe_q <= 1'b0;
							2'h2: sda_oe_q <= 1'b0;
							default: st_q <= isr_pkg::MS_GAP;
						endcase
					end
				end
				isr_pkg::MS_GAP: begin
					// Gap after every stop, which covers the general call case
					if (tmr_q == GAP_LAST)
						st_q <= isr_pkg::MS_IDLE;
				end
				default: st_q <= isr_pkg::MS_IDLE;
			endcase
		end
	end

	assign bus.m_scl_o  = 1'b0;
	assign bus.m_scl_oe = scl_oe_q;
	assign bus.m_sda_o  = 1'b0;
	assign bus.m_sda_oe = sda_oe_q;
	assign cmd_ready_o  = rdy_q;
	assign rsp_valid_o  = rv_q;
	assign rsp_data_o   = rdat_q;
	assign rsp_ack_o    = rack_q;

endmodule : isr_host_end

// >>> tb/isr_bus_sva.sv
// Protocol checker for the two-wire bus between host end and register port
`timescale 1ns/1ps
module isr_chk (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic m_scl_o,
	input wire logic m_scl_oe,
	input wire logic m_sda_o,
	input wire logic m_sda_oe,
	input wire logic s_sda_o,
	input wire logic s_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	// =====
	// Wire tracking
	logic       scl_q;
	logic       sda_q;
	logic       idle_q;
	logic [3:0] bit_q;
	wire        start_w = scl && scl_q && sda_q && !sda;
	wire        stop_w  = scl && scl_q && !sda_q && sda;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			scl_q <= 1'h1;
			sda_q <= 1'h1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			idle_q <= 1'h1;
		end else if (start_w || stop_w) begin
			idle_q <= stop_w;
		end
	end

	// Saturates so long bursts never alias onto the address byte
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bit_q <= 4'hF;
		end else if (start_w) begin
			bit_q <= 4'h0;
		end else if (scl && !scl_q && bit_q != 4'hF) begin
			bit_q <= bit_q + 4'h1;
		end
	end

	// =====
	// Assertions
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	a_open_drain: assert property (!(s_sda_oe && s_sda_o) && !(m_sda_oe && m_sda_o) && !(m_scl_oe && m_scl_o))
		else $error("driven level not low");
	a_dev_sync: assert property ($changed(s_sda_oe) |-> !$past(scl) && !$past(scl, 2))
		else $error("device data moved before synced SCL low");
	a_dev_no_cond: assert property (scl && $stable(scl) && $changed(sda) |-> !s_sda_oe && !$past(s_sda_oe))
		else $error("device moved SDA with SCL high");
	a_idle_quiet: assert property (idle_q |-> !s_sda_oe)
		else $error("device drives while idle");
	a_hdr_quiet: assert property (scl && !scl_q && bit_q < 4'h8 |-> !s_sda_oe)
		else $error("device drives during address byte");
	a_ack_held: assert property ($rose(s_sda_oe) |-> s_sda_oe [*8])
		else $error("device pull too short");
	a_scl_high: assert property ($rose(scl) |-> scl [*8])
		else $error("SCL high too short");
	a_stop_release: assert property (stop_w |=> !s_sda_oe [*8])
		else $error("device drives after stop");
endmodule : isr_chk

// >>> tb/tb.sv
// Self-checking bench: host end talks to the register port end over the bus
`timescale 1ns/1ps
module tb;
	logic              clk_i;
	logic              sys_rst_i;
	logic              cmd_valid_i;
	isr_pkg::isr_cmd_t cmd_i;
	logic [7:0]        cmd_data_i;
	logic              cmd_last_i;
	logic              cmd_ready_o;
	logic              rsp_valid_o;
	logic [7:0]        rsp_data_o;
	logic              rsp_ack_o;
	logic [1:0]        adr_sel_i;
	logic [7:0]        reg_rdata_i;
	logic [7:0]        reg_addr_o;
	logic              reg_wr_o;
	logic [7:0]        reg_wdata_o;
	logic              soft_rst_o;
	logic              reg_rd_o;
	logic [15:0]       wr_q[$];
	int                n_soft = 0;
	int                n_rd = 0;
	int                n_fail = 0;
	int                samples_checked = 0;

	isr_if bus_if ();

	isr_host_end u_isr_host_end (.bus(bus_if), .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i),
		.cmd_i(cmd_i), .cmd_data_i(cmd_data_i), .cmd_last_i(cmd_last_i), .cmd_ready_o(cmd_ready_o),
		.rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_ack_o(rsp_ack_o));
	isr_dev_end u_isr_dev_end (.bus(bus_if), .clk_i(clk_i), .sys_rst_i(sys_rst_i), .adr_sel_i(adr_sel_i),
		.reg_rdata_i(reg_rdata_i), .reg_addr_o(reg_addr_o), .reg_wr_o(reg_wr_o), .reg_wdata_o(reg_wdata_o),
		.reg_rd_o(reg_rd_o), .soft_rst_o(soft_rst_o));
	isr_chk u_isr_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .m_scl_o(bus_if.m_scl_o), .m_scl_oe(bus_if.m_scl_oe),
		.m_sda_o(bus_if.m_sda_o), .m_sda_oe(bus_if.m_sda_oe), .s_sda_o(bus_if.s_sda_o),
		.s_sda_oe(bus_if.s_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));

	// Register contents follow the address so read data is predictable
	assign reg_rdata_i = reg_addr_o ^ 8'h5A;

	always @(posedge clk_i) begin
		if (reg_wr_o === 1'h1) begin
			wr_q.push_back({reg_addr_o, reg_wdata_o});
		end
		if (soft_rst_o === 1'h1) begin
			n_soft++;
		end
		if (reg_rd_o === 1'h1) begin
			n_rd++;
		end
	end

	initial begin
		clk_i = 1'h0;
		forever #5 clk_i = ~clk_i;
	end

	// =====
	// Checking
	task automatic stop_test();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// =====
	// Host commands
	// Always passes one edge first, so a ready level left over from the take edge is never reused
	task automatic wait_for(input logic rsp);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
			if (n > 20000) begin
				chk(16'h0000, 16'h0001);
				stop_test();
			end
		end while ((rsp ? rsp_valid_o : cmd_ready_o) !== 1'h1);
	endtask : wait_for

	task automatic xfer(input isr_pkg::isr_cmd_t c, input logic [7:0] d, input logic last);
		wait_for(1'h0);
		cmd_valid_i <= 1'h1;
		cmd_i       <= c;
		cmd_data_i  <= d;
		cmd_last_i  <= last;
		@(posedge clk_i);
		cmd_valid_i <= 1'h0;
		if (c inside {isr_pkg::CMD_WRITE, isr_pkg::CMD_READ}) begin
			wait_for(1'h1);
		end
	endtask : xfer

	task automatic wb(input logic [7:0] d, input logic a);
		xfer(isr_pkg::CMD_WRITE, d, 1'h0);
		chk(16'(rsp_ack_o), 16'(a));
	endtask : wb

	task automatic rb(input logic last, input logic [7:0] exp);
		xfer(isr_pkg::CMD_READ, 8'h00, last);
		chk(16'(rsp_data_o), 16'(exp));
	endtask : rb

	// =====
	// Scenarios
	task automatic t_mismatch();
		xfer(isr_pkg::CMD_START, 8'h00, 1'h0);
		wb(8'hB2, 1'h0);
		xfer(isr_pkg::CMD_STOP, 8'h00, 1'h0);
	endtask : t_mismatch

	task automatic t_general_call();
		adr_sel_i <= 2'h1;
		xfer(isr_pkg::CMD_START, 8'h00, 1'h0);
		wb(8'h00, 1'h1);
		wb(8'h06, 1'h1);
		xfer(isr_pkg::CMD_STOP, 8'h00, 1'h0);
		chk(16'(n_soft), 16'h0001);
	endtask : t_general_call

	// Relatched strap selects 0x59; write wraps past 0xFF, then a read from 0xFF wraps too
	task automatic t_write_read();
		xfer(isr_pkg::CMD_START, 8'h00, 1'h0);
		wb(8'hB2, 1'h1);
		wb(8'hFF, 1'h1);
		wb(8'hA5, 1'h1);
		wb(8'h3C, 1'h1);
		xfer(isr_pkg::CMD_START, 8'h00, 1'h0);
		wb(8'hB2, 1'h1);
		wb(8'hFF, 1'h1);
		xfer(isr_pkg::CMD_START, 8'h00, 1'h0);
		wb(8'hB3, 1'h1);
		rb(1'h0, 8'hA5);
		rb(1'h1, 8'h5A);
		xfer(isr_pkg::CMD_STOP, 8'h00, 1'h0);
		chk(16'(n_rd), 16'h0002);
		chk(16'(wr_q.size()), 16'h0002);
		chk(wr_q[0], 16'hFFA5);
		chk(wr_q[1], 16'h003C);
	endtask : t_write_read

	// Address-only command: straps move to 0x5A without a soft reset
	task automatic t_gc_latch();
		adr_sel_i <= 2'h2;
		xfer(isr_pkg::CMD_START, 8'h00, 1'h0);
		wb(8'h00, 1'h1);
		wb(8'h04, 1'h1);
		xfer(isr_pkg::CMD_STOP, 8'h00, 1'h0);
		chk(16'(n_soft), 16'h0001);
		xfer(isr_pkg::CMD_START, 8'h00, 1'h0);
		wb(8'hB4, 1'h1);
		xfer(isr_pkg::CMD_STOP, 8'h00, 1'h0);
	endtask : t_gc_latch

	// Unknown command is acked but neither resets nor relatches
	task automatic t_gc_other();
		adr_sel_i <= 2'h3;
		xfer(isr_pkg::CMD_START, 8'h00, 1'h0);
		wb(8'h00, 1'h1);
		wb(8'h08, 1'h1);
		xfer(isr_pkg::CMD_STOP, 8'h00, 1'h0);
		chk(16'(n_soft), 16'h0001);
		xfer(isr_pkg::CMD_START, 8'h00, 1'h0);
		wb(8'hB4, 1'h1);
		xfer(isr_pkg::CMD_STOP, 8'h00, 1'h0);
	endtask : t_gc_other

	initial begin
		sys_rst_i   = 1'h1;
		cmd_valid_i = 1'h0;
		cmd_i       = isr_pkg::CMD_START;
		cmd_data_i  = 8'h00;
		cmd_last_i  = 1'h0;
		adr_sel_i   = 2'h0;
		repeat (8) @(posedge clk_i);
		chk({reg_addr_o, 7'h00, bus_if.s_sda_oe}, 16'h0000);
		sys_rst_i <= 1'h0;
		t_mismatch();
		t_general_call();
		t_write_read();
		t_gc_latch();
		t_gc_other();
		stop_test();
	end
endmodule : tb
